// File: rtl/acp_map.svh
`ifndef ACP_MAP_SVH
`define ACP_MAP_SVH

// command codes
`define ACP_CMD_AUTOCLASS_CTRL   8'h50
`define ACP_CMD_CH1_AC_POWER     8'h51
`define ACP_CMD_CH2_AC_POWER     8'h52
`define ACP_CMD_CH3_AC_POWER     8'h53
`define ACP_CMD_CH4_AC_POWER     8'h54
`define ACP_CMD_FOLDBACK_SEL     8'h55

// field positions
`define ACP_CTRL_MAC_LSB         4
`define ACP_CTRL_AAC_LSB         0
`define ACP_FOLD_ALTFB_LSB       4
`define ACP_FOLD_ALTIR_LSB       0

// reset values
`define ACP_CTRL_RESET           8'h00
`define ACP_AC_POWER_RESET       7'h00
`define ACP_FOLD_RESET           8'h00
`define ACP_PCUT_RESET           9'h000
`define ACP_UNMAPPED_READ        8'h00
`define ACP_MAC_RESET            4'h0
`define ACP_AAC_RESET            4'h0

// margin range tops, in 0.5 W counts (inclusive, gaps go low)
`define ACP_TOP_18W5             8'h26
`define ACP_TOP_25W5             8'h34
`define ACP_TOP_36W5             8'h49
`define ACP_TOP_45W              8'h5a
`define ACP_TOP_51W5             8'h67
`define ACP_TOP_58W              8'h74
`define ACP_TOP_63W              8'h7e
`define ACP_TOP_68W              8'h88
`define ACP_TOP_73W              8'h92

// margins, in 0.5 W counts
`define ACP_MARGIN_0W5           5'h01
`define ACP_MARGIN_1W            5'h02
`define ACP_MARGIN_2W            5'h04
`define ACP_MARGIN_3W            5'h06
`define ACP_MARGIN_4W            5'h08
`define ACP_MARGIN_5W            5'h0a
`define ACP_MARGIN_6W            5'h0c
`define ACP_MARGIN_7W            5'h0e
`define ACP_MARGIN_8W            5'h10
`define ACP_MARGIN_9W            5'h12

`endif

// File: rtl/acp_pkg.sv
package acp_pkg;

  typedef struct packed {
    logic [3:0]      done;
    logic [3:0][6:0] count;
  } acp_meas_t;

  typedef struct packed {
    logic [3:0][3:0] aclass;
    logic [1:0]      single_sig;
    logic [3:0]      power_on;
  } acp_chan_t;

  typedef struct packed {
    logic [3:0][8:0] two_pair;
    logic [1:0][8:0] four_pair;
  } acp_pcut_t;

  typedef struct packed {
    logic [3:0][6:0] pac;
    logic [3:0]      mac;
    logic [3:0]      aac;
    logic [7:0]      fold;
    acp_pcut_t       pcut;
    logic [3:0]      pend;
    logic [3:0]      busy;
    logic [3:0]      start;
    logic [7:0]      rdata;
  } acp_state_t;

endpackage : acp_pkg

// File: rtl/acp_power_adjust.sv
`include "acp_map.svh"

module acp_power_adjust #(
  parameter logic [15:0][8:0] CLASS_LIMIT = {16{9'h1ff}}
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic                 ce,
  // command-code register port
  input  wire logic [7:0]           reg_cmd,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata,
  // measurement engine
  input  wire acp_pkg::acp_meas_t   meas,
  output logic      [3:0]           meas_start,
  // channel status
  input  wire acp_pkg::acp_chan_t   chan,
  // host preset of power-cut limits
  input  wire logic [5:0]           pcut_set,
  input  wire logic [8:0]           pcut_value,
  // power-cut limits and foldback selects
  output acp_pkg::acp_pcut_t        pcut,
  output logic      [3:0]           alt_operational_foldback_en,
  output logic      [3:0]           alt_inrush_foldback_en
);
  import acp_pkg::*;

  acp_state_t q;
  acp_state_t d;

  // margin in 0.5 W counts for a power in 0.5 W counts
  function automatic logic [4:0] acp_margin(input logic [7:0] p);
    logic [4:0] m;
    m = `ACP_MARGIN_9W;
    // inclusive tops so a value in a gap lands on the lower row
    if (p <= `ACP_TOP_18W5) begin
      m = `ACP_MARGIN_0W5;
    end else if (p <= `ACP_TOP_25W5) begin
      m = `ACP_MARGIN_1W;
    end else if (p <= `ACP_TOP_36W5) begin
      m = `ACP_MARGIN_2W;
    end else if (p <= `ACP_TOP_45W) begin
      m = `ACP_MARGIN_3W;
    end else if (p <= `ACP_TOP_51W5) begin
      m = `ACP_MARGIN_4W;
    end else if (p <= `ACP_TOP_58W) begin
      m = `ACP_MARGIN_5W;
    end else if (p <= `ACP_TOP_63W) begin
      m = `ACP_MARGIN_6W;
    end else if (p <= `ACP_TOP_68W) begin
      m = `ACP_MARGIN_7W;
    end else if (p <= `ACP_TOP_73W) begin
      m = `ACP_MARGIN_8W;
    end
    return m;
  endfunction : acp_margin

  // measured power plus its margin
  function automatic logic [8:0] acp_with_margin(input logic [7:0] p);
    return {1'b0, p} + {4'h0, acp_margin(p)};
  endfunction : acp_with_margin

  // limit fits the channel's assigned class range
  function automatic logic acp_fits(input logic [8:0] v,
                                    input logic [3:0] cls);
    return v <= CLASS_LIMIT[cls];
  endfunction : acp_fits

  always_comb begin
    logic [7:0] sum;
    logic [8:0] tot;
    logic       ok;
    sum = 8'h00;
    tot = 9'h000;
    ok  = 1'b0;
    d   = q;
    d.start = 4'h0;

    // capture results, close the measurement and drop the request
    for (int i = 0; i < 4; i++) begin
      if (meas.done[i]) begin
        d.pac[i]  = meas.count[i];
        d.pend[i] = 1'b1;
        d.busy[i] = 1'b0;
        d.mac[i]  = 1'b0;
      end
    end

    // host presets of the limits; auto results below override them
    for (int i = 0; i < 4; i++) begin
      if (pcut_set[i]) begin
        d.pcut.two_pair[i] = pcut_value;
      end
    end
    for (int p = 0; p < 2; p++) begin
      if (pcut_set[4 + p]) begin
        d.pcut.four_pair[p] = pcut_value;
      end
    end

    // one cycle after the result lands the limit is already updated,
    // far inside the allowed settling window
    for (int p = 0; p < 2; p++) begin
      if (chan.single_sig[p]) begin
        if (q.pend[2 * p] || q.pend[2 * p + 1]) begin
          sum = {1'b0, q.pac[2 * p]} + {1'b0, q.pac[2 * p + 1]};
          tot = acp_with_margin(sum);
          // either enable of the pair is enough
          ok = q.aac[2 * p] || q.aac[2 * p + 1];
          if (ok && acp_fits(tot, chan.aclass[2 * p])) begin
            d.pcut.four_pair[p] = tot;
          end
          // two-pair limits are left as they were
        end
      end else begin
        for (int k = 0; k < 2; k++) begin
          if (q.pend[2 * p + k] && q.aac[2 * p + k]) begin
            tot = acp_with_margin({1'b0, q.pac[2 * p + k]});
            if (acp_fits(tot, chan.aclass[2 * p + k])) begin
              d.pcut.two_pair[2 * p + k] = tot;
            end
          end
        end
      end
    end
    d.pend = d.pend & ~q.pend;

    // launch requested measurements the cycle after the bit is seen
    for (int i = 0; i < 4; i++) begin
      // single-signature pair needs both request bits
      ok = !chan.single_sig[i / 2] || q.mac[i ^ 1];
      if (q.mac[i] && !q.busy[i] && ok && !meas.done[i]) begin
        d.start[i] = 1'b1;
        d.busy[i]  = 1'b1;
      end
    end

    // turn-on discards stale requests
    for (int i = 0; i < 4; i++) begin
      if (chan.power_on[i]) begin
        d.mac[i]   = 1'b0;
        d.busy[i]  = 1'b0;
        d.start[i] = 1'b0;
      end
    end

    // host writes; a host write in the same cycle as a hardware clear wins
    if (reg_wr) begin
      unique case (reg_cmd)
        `ACP_CMD_AUTOCLASS_CTRL: begin
          d.mac = reg_wdata[`ACP_CTRL_MAC_LSB +: 4];
          d.aac = reg_wdata[`ACP_CTRL_AAC_LSB +: 4];
        end
        `ACP_CMD_FOLDBACK_SEL: begin
          d.fold = reg_wdata;
        end
        default: begin
        end
      endcase
    end

    // read data is held until the next read
    if (reg_rd) begin
      unique case (reg_cmd)
        `ACP_CMD_AUTOCLASS_CTRL: d.rdata = {q.mac, q.aac};
        `ACP_CMD_CH1_AC_POWER:   d.rdata = {1'b0, q.pac[0]};
        `ACP_CMD_CH2_AC_POWER:   d.rdata = {1'b0, q.pac[1]};
        `ACP_CMD_CH3_AC_POWER:   d.rdata = {1'b0, q.pac[2]};
        `ACP_CMD_CH4_AC_POWER:   d.rdata = {1'b0, q.pac[3]};
        `ACP_CMD_FOLDBACK_SEL:   d.rdata = q.fold;
        default:                 d.rdata = `ACP_UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q.pac                <= {4{`ACP_AC_POWER_RESET}};
      q.mac                <= `ACP_MAC_RESET;
      q.aac                <= `ACP_AAC_RESET;
      q.fold               <= `ACP_FOLD_RESET;
      q.pcut.two_pair      <= {4{`ACP_PCUT_RESET}};
      q.pcut.four_pair     <= {2{`ACP_PCUT_RESET}};
      q.pend               <= 4'h0;
      q.busy               <= 4'h0;
      q.start              <= 4'h0;
      q.rdata              <= `ACP_UNMAPPED_READ;
    end else if (ce) begin
      q <= d;
    end
  end

  assign reg_rdata  = q.rdata;
  assign meas_start = q.start;
  assign pcut       = q.pcut;
  // curve selects apply to the power-on that follows
  assign alt_operational_foldback_en =
    q.fold[`ACP_FOLD_ALTFB_LSB +: 4];
  assign alt_inrush_foldback_en =
    q.fold[`ACP_FOLD_ALTIR_LSB +: 4];

endmodule : acp_power_adjust

// File: test/acp_power_adjust_checker.sv
module acp_power_adjust_checker (
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              resetn,
  input wire logic              ce,
  // register port
  input wire logic [7:0]        reg_cmd,
  input wire logic              reg_wr,
  input wire logic [7:0]        reg_wdata,
  // measurement, channels, limits
  input wire acp_pkg::acp_meas_t meas,
  input wire logic [3:0]        meas_start,
  input wire acp_pkg::acp_chan_t chan,
  input wire acp_pkg::acp_pcut_t pcut,
  input wire logic [3:0]        alt_operational_foldback_en,
  input wire logic [3:0]        alt_inrush_foldback_en
);
  import acp_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire wr_ok = ce && reg_wr;

  AST_ALT_OP: assert property (wr_ok && reg_cmd == 8'h55 |=>
    alt_operational_foldback_en == $past(reg_wdata[7:4]))
    else $error("operational foldback select wrong");
  AST_ALT_IR: assert property (wr_ok && reg_cmd == 8'h55 |=>
    alt_inrush_foldback_en == $past(reg_wdata[3:0]))
    else $error("inrush foldback select wrong");
  AST_START: assert property (wr_ok && reg_cmd == 8'h50 &&
    reg_wdata[4] && !chan.single_sig[0] && !meas_start[0] |-> ##2
    meas_start[0]) else $error("measurement did not start");
  AST_PAIR: assert property (chan.single_sig[1] &&
    meas_start[2] |-> meas_start[3]) else $error("pair start split");
  AST_KEEP2P: assert property (chan.single_sig[1] &&
    meas.done[2] |=> $stable(pcut.two_pair[2])[*2])
    else $error("two-pair limit moved");
  AST_KEEP4P: assert property (!chan.single_sig[0] &&
    meas.done[0] |=> $stable(pcut.four_pair[0])[*2])
    else $error("four-pair limit moved");
  AST_PWON: assert property (chan.power_on[2] |=>
    !meas_start[2] && !meas_start[3]) else $error("start after power-on");
  AST_PWON_HOLD: assert property (chan.power_on[2] |=>
    $stable(pcut.four_pair[1])) else $error("limit moved on power-on");
  cover property (meas_start[0]);
  cover property (meas_start[2] && meas_start[3]);
  cover property (chan.power_on[2]);
endmodule : acp_power_adjust_checker

bind acp_power_adjust acp_power_adjust_checker chk_u (
  .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .reg_cmd(reg_cmd),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .meas(meas),
  .meas_start(meas_start), .chan(chan), .pcut(pcut),
  .alt_operational_foldback_en(alt_operational_foldback_en),
  .alt_inrush_foldback_en(alt_inrush_foldback_en));

// File: test/acp_host_model.sv
module acp_host_model (
  // clock
  input wire logic       clk_sys,
  // register port, host side
  output logic [7:0]     reg_cmd,
  output logic           reg_wr,
  output logic           reg_rd,
  output logic [7:0]     reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_cmd = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // host owns limits while auto-adjust is off
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_cmd = c;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;  // no stale data once released
  endtask : wr
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_cmd = c;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
endmodule : acp_host_model

// File: test/testbench.sv
module testbench;
  import acp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // class 4 capped at 8 W to reach the over-class case
  localparam logic [15:0][8:0] LIM = {{11{9'h1ff}}, 9'h010, {4{9'h1ff}}};
  logic        clk_sys = 1'b0;
  logic        resetn, ce, reg_wr, reg_rd;
  logic [7:0]  reg_cmd, reg_wdata, reg_rdata, d;
  acp_meas_t   meas;
  acp_chan_t   chan;
  acp_pcut_t   pcut;
  logic [3:0]  meas_start, alt_op, alt_ir;
  logic [5:0]  pcut_set;
  logic [8:0]  pcut_value;
  int          n_errors = 0;
  int          total_checks = 0;
  logic [6:0]  cnt [15] = '{37, 38, 39, 52, 53, 73, 74, 90, 91, 103, 104,
                            116, 117, 126, 127};
  logic [6:0]  pa [4] = '{20, 64, 70, 100};
  logic [6:0]  pb [4] = '{10, 63, 70, 100};

  always #2 clk_sys = ~clk_sys;
  acp_host_model host_u (.clk_sys(clk_sys), .reg_cmd(reg_cmd),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  acp_power_adjust #(.CLASS_LIMIT(LIM)) dut_u (.clk_sys(clk_sys),
    .resetn(resetn), .ce(ce), .reg_cmd(reg_cmd), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .meas(meas), .meas_start(meas_start), .chan(chan),
    .pcut_set(pcut_set), .pcut_value(pcut_value), .pcut(pcut),
    .alt_operational_foldback_en(alt_op), .alt_inrush_foldback_en(alt_ir));

  task automatic chk(input string nm, input logic [8:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // range tops in 0.5 W counts; a gap takes the lower row
  function automatic logic [8:0] mg(input logic [7:0] c);
    logic [7:0] top [9] = '{38, 52, 73, 90, 103, 116, 126, 136, 146};
    for (int i = 0; i < 9; i++) if (c <= top[i]) return i == 0 ? 1 : 2 * i;
    return 18;
  endfunction : mg
  task automatic preset(input int i, input logic [8:0] v);
    pcut_set[i] = 1'b1;
    pcut_value = v;
    @(posedge clk_sys);
    #1;
    pcut_set = '0;
  endtask : preset
  task automatic meas_run(input logic [7:0] wv, input int ch, input bit pr,
                          input logic [6:0] a, input logic [6:0] b);
    int k = 0;
    host_u.wr(8'h50, wv);
    while (meas_start[ch] !== 1'b1 && k < 20) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk("start", {8'h00, meas_start[ch]}, 9'h001);
    if (pr) chk("pair_start", {8'h00, meas_start[ch+1]}, 9'h001);
    @(posedge clk_sys);
    #1;
    meas.count[ch] = a;
    meas.done[ch] = 1'b1;
    if (pr) meas.count[ch+1] = b;
    if (pr) meas.done[ch+1] = 1'b1;
    @(posedge clk_sys);
    #1;
    meas.done = '0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : meas_run
  task automatic close_out;
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  initial begin
    #200000;
    n_errors++;
    close_out();
  end
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    meas = '0;
    chan = '0;
    chan.aclass[1] = 4'h4;
    pcut_set = '0;
    pcut_value = 9'h000;
    repeat (8) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    for (int a = 8'h50; a <= 8'h56; a++) begin
      host_u.rd(a[7:0], d);
      chk("reset_read", {1'b0, d}, 9'h000);
    end
    host_u.wr(8'h55, 8'ha5);
    chk("alt_op", {5'h00, alt_op}, 9'h00a);
    chk("alt_ir", {5'h00, alt_ir}, 9'h005);
    // a write while the clock enable is low must not land
    ce = 1'b0;
    host_u.wr(8'h55, 8'h5a);
    ce = 1'b1;
    chk("alt_op_frozen", {5'h00, alt_op}, 9'h00a);
    chk("alt_ir_frozen", {5'h00, alt_ir}, 9'h005);
    host_u.wr(8'h51, 8'h7f);
    host_u.rd(8'h51, d);
    chk("ro_power", {1'b0, d}, 9'h000);
    foreach (cnt[i]) begin
      meas_run(8'h11, 0, 1'b0, cnt[i], 7'h00);
      chk("two_pair0", pcut.two_pair[0], cnt[i] + mg(cnt[i]));
    end
    host_u.rd(8'h51, d);
    chk("power1", {1'b0, d}, 9'h07f);
    host_u.rd(8'h50, d);
    chk("ctrl", {1'b0, d}, 9'h001);
    chk("four_pair0", pcut.four_pair[0], 9'h000);
    preset(1, 9'h055);
    meas_run(8'h22, 1, 1'b0, 7'd20, 7'h00);
    chk("two_pair1", pcut.two_pair[1], 9'h055);
    chan.single_sig = 2'b10;
    preset(2, 9'h033);
    host_u.wr(8'h50, 8'h44);
    repeat (6) @(posedge clk_sys);
    host_u.rd(8'h50, d);
    chk("ctrl_held", {1'b0, d}, 9'h044);
    chan.power_on[2] = 1'b1;  // foldback chosen beforehand
    @(posedge clk_sys);
    #1;
    chan.power_on = '0;
    host_u.rd(8'h50, d);
    chk("ctrl_pwon", {1'b0, d}, 9'h004);
    foreach (pa[i]) begin
      meas_run(8'hc4, 2, 1'b1, pa[i], pb[i]);
      chk("four_pair1", pcut.four_pair[1], pa[i] + pb[i]
        + mg(pa[i] + pb[i]));
      chk("two_pair2", pcut.two_pair[2], 9'h033);
    end
    close_out();
  end
endmodule : testbench
